// File: src/iop_pkg.sv
package iop_pkg;
	// port widths
	localparam int P1_W = 8;
	localparam int P3_W = 8;
	localparam int PCTL_W = 4;

	// clocking
	localparam int CLK_SYS_MHZ = 125;
	localparam int OSC_PER_MC = 12;
	localparam int OSC_PER_HALF = 2;
	localparam int HALF_PER_MC = OSC_PER_MC / OSC_PER_HALF;
	localparam logic [2:0] PHASE_LAST = 3'(HALF_PER_MC - 1);
	localparam logic [2:0] PHASE_ZERO = 3'h0;
	localparam logic [2:0] PHASE_STEP = 3'h1;

	// reset hold
	localparam int RST_HOLD_MC = 2;
	localparam int RST_HOLD_CLK = RST_HOLD_MC * OSC_PER_MC;

	// pin reset level and pull-up maps
	localparam logic [P1_W-1:0] P1_RESET = 8'hff;
	localparam logic [P3_W-1:0] P3_RESET = 8'hff;
	localparam logic [P1_W-1:0] P1_PULL_MASK = 8'hfc;
	localparam logic [P3_W-1:0] P3_PULL_MASK = 8'hbf;
	localparam logic [P3_W-1:0] P3_PIN_MASK = 8'hbf;
	localparam logic [P1_W-1:0] ALL_ZERO = 8'h00;
	localparam logic [P1_W-1:0] ALL_ONE = 8'hff;

	// bit positions
	localparam int CMP_POS_BIT = 0;
	localparam int CMP_NEG_BIT = 1;
	localparam int RXD_BIT = 0;
	localparam int TXD_BIT = 1;
	localparam int EXT0_BIT = 2;
	localparam int EXT1_BIT = 3;
	localparam int TMR0_BIT = 4;
	localparam int TMR1_BIT = 5;
	localparam int CMP_OUT_BIT = 6;
	localparam int PCTL_BIT0 = 2;
	localparam int PCTL_BIT3 = 5;

	// power modes
	typedef enum logic [2:0] {
		IOP_RUN   = 3'h1,
		IOP_IDLE  = 3'h2,
		IOP_PDOWN = 3'h4
	} iop_mode_t;
endpackage

// File: src/iop_ports.sv
// Notes on behaviour
// - eight bidirectional first-port pins with own latches
// - latch one frees pin, zero holds low
// - first-port bits 0,1 feed comparator, no pull-up
// - seven second-port pins with internal pull-ups
// - second-port bit 6 reads comparator output
// - latch one pulls pin high, readable
// - second-port alternate serial, interrupt, timer functions
// - first port carries code data when programming
// - second-port pins take programming control signals
// - reset input forces all pins high immediately
// - reset held two machine cycles resets device
// - one machine cycle per twelve oscillator cycles
// - oscillator divided by two with flip-flop
// - static logic keeps state when clock stops
// - idle halts processor, peripherals keep running
// - power-down stops oscillator until hardware reset
// - idle ends on enabled interrupt or reset
// - reset reinitialises latches, leaves memory alone
`timescale 1ns/1ns
`default_nettype none
module iop_ports
	import iop_pkg::*;
(
	// clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              RST,
	// latch writes from the core
	input  wire logic              P1_WR_EN,
	input  wire logic [P1_W-1:0]   P1_WR_DATA,
	input  wire logic              P3_WR_EN,
	input  wire logic [P3_W-1:0]   P3_WR_DATA,
	// pin reads to the core
	output logic      [P1_W-1:0]   P1_RD_DATA,
	output logic      [P3_W-1:0]   P3_RD_DATA,
	// first port pins
	input  wire logic [P1_W-1:0]   P1_IN,
	output logic      [P1_W-1:0]   P1_OUT,
	output logic      [P1_W-1:0]   P1_OE_N,
	output logic      [P1_W-1:0]   P1_PULLUP_EN,
	// second port pins
	input  wire logic [P3_W-1:0]   P3_IN,
	output logic      [P3_W-1:0]   P3_OUT,
	output logic      [P3_W-1:0]   P3_OE_N,
	output logic      [P3_W-1:0]   P3_PULLUP_EN,
	// comparator
	input  wire logic              COMPARATOR_RESULT,
	output logic                   COMPARATOR_POSITIVE_INPUT,
	output logic                   COMPARATOR_NEGATIVE_INPUT,
	// alternate functions
	input  wire logic              SERIAL_TX,
	output logic                   SERIAL_RX,
	output logic                   EXTERNAL_INTERRUPT_ZERO_PIN,
	output logic                   EXTERNAL_INTERRUPT_ONE_PIN,
	output logic                   TIMER_ZERO_COUNT_INPUT,
	output logic                   TIMER_ONE_COUNT_INPUT,
	// flash programming
	input  wire logic              PROG_MODE,
	input  wire logic              PROG_DATA_OE,
	input  wire logic [P1_W-1:0]   PROG_DATA_WR,
	output logic      [P1_W-1:0]   PROG_DATA_RD,
	output logic      [PCTL_W-1:0] PROG_CTRL,
	// power modes and clocking
	input  wire logic              IDLE_REQ,
	input  wire logic              PDOWN_REQ,
	input  wire logic              WAKE_IRQ,
	output logic                   CPU_HALT,
	output logic                   OSC_RUN,
	output logic                   MACHINE_CYCLE,
	output logic                   DEVICE_RESET
);

	iop_mode_t            mode_r;
	logic                 osc_run;
	logic                 half_r;
	logic [2:0]           phase_r;
	logic                 mc_pulse;
	logic [RST_HOLD_CLK-1:0] rst_hist_r;
	logic [P1_W-1:0]      p1_latch_r;
	logic [P3_W-1:0]      p3_latch_r;
	logic [P1_W-1:0]      p1_meta_r;
	logic [P1_W-1:0]      p1_sync_r;
	logic [P3_W-1:0]      p3_meta_r;
	logic [P3_W-1:0]      p3_sync_r;
	logic [P1_W-1:0]      prog_data_r;
	logic                 prog_oe_r;
	logic [P3_W-1:0]      p3_drive;

	// power mode: only a hardware reset leaves power-down
	// power-down until reset
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			mode_r <= IOP_RUN;
		end else begin
			unique case (mode_r)
				IOP_RUN: begin
					if (PDOWN_REQ) begin
						mode_r <= IOP_PDOWN;
					end else if (IDLE_REQ) begin
						mode_r <= IOP_IDLE;
					end
				end
				IOP_IDLE: begin
					if (WAKE_IRQ) begin
						mode_r <= IOP_RUN;
					end
				end
				IOP_PDOWN: begin
					mode_r <= IOP_PDOWN;
				end
				default: begin
					mode_r <= IOP_RUN;
				end
			endcase
		end
	end

	assign osc_run = (mode_r != IOP_PDOWN);
	assign OSC_RUN = osc_run;
	assign CPU_HALT = (mode_r != IOP_RUN);

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			half_r <= 1'b0;
		end else if (osc_run) begin
			half_r <= ~half_r;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			phase_r <= PHASE_ZERO;
		end else if (osc_run && half_r) begin
			phase_r <= (phase_r == PHASE_LAST) ? PHASE_ZERO : phase_r + PHASE_STEP;
		end
	end

	assign mc_pulse = osc_run && half_r && (phase_r == PHASE_LAST);
	assign MACHINE_CYCLE = mc_pulse;

	// reset level history; no reset of its own since it watches the reset
	// full reset after hold
	always_ff @(posedge CLK_SYS) begin
		rst_hist_r <= {rst_hist_r[RST_HOLD_CLK-2:0], RST};
	end

	assign DEVICE_RESET = &rst_hist_r;

	// latches go to ones without a clock edge
	// pins forced high
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			p1_latch_r <= P1_RESET;
		end else if (P1_WR_EN) begin
			p1_latch_r <= P1_WR_DATA;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			p3_latch_r <= P3_RESET;
		end else if (P3_WR_EN) begin
			p3_latch_r <= P3_WR_DATA;
		end
	end

	// programming data path, registered
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			prog_data_r <= ALL_ONE;
			prog_oe_r <= 1'b0;
		end else begin
			prog_data_r <= PROG_DATA_WR;
			prog_oe_r <= PROG_MODE && PROG_DATA_OE;
		end
	end

	// pins only sink unless programming drives them: a one releases the pin, to the pull-up on bits 2 to 7 only
	// zero holds pin low
	always_comb begin
		if (prog_oe_r && !RST) begin
			P1_OUT = prog_data_r;
			P1_OE_N = ALL_ZERO;
		end else begin
			P1_OUT = ALL_ZERO;
			P1_OE_N = p1_latch_r;
		end
	end

	assign P1_PULLUP_EN = P1_PULL_MASK;

	// serial transmit shares the latch; bit 6 has no pin
	// transmit alternate output
	always_comb begin
		p3_drive = p3_latch_r;
		// reset lifts transmit too, so every pin reads high at once
		p3_drive[TXD_BIT] = p3_latch_r[TXD_BIT] & (SERIAL_TX | RST);
		p3_drive[CMP_OUT_BIT] = 1'b1;
	end

	assign P3_OUT = ALL_ZERO;
	assign P3_OE_N = p3_drive | ~P3_PIN_MASK;
	assign P3_PULLUP_EN = P3_PULL_MASK;

	// two stages on the machine-cycle enable, one for second-port bit 6; the first is read only by the second
	// synchronised pin reads
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			p1_meta_r <= ALL_ONE;
			p1_sync_r <= ALL_ONE;
		end else if (mc_pulse) begin
			p1_meta_r <= P1_IN;
			p1_sync_r <= p1_meta_r;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			p3_meta_r <= ALL_ONE;
			p3_sync_r <= ALL_ONE;
		end else if (mc_pulse) begin
			p3_meta_r <= P3_IN;
			p3_sync_r <= p3_meta_r;
			p3_sync_r[CMP_OUT_BIT] <= COMPARATOR_RESULT;
		end
	end

	assign P1_RD_DATA = p1_sync_r;
	assign P3_RD_DATA = p3_sync_r;
	assign PROG_DATA_RD = p1_sync_r;
	// comparator inputs sampled, the analog path is elsewhere
	assign COMPARATOR_POSITIVE_INPUT = p1_sync_r[CMP_POS_BIT];
	assign COMPARATOR_NEGATIVE_INPUT = p1_sync_r[CMP_NEG_BIT];

	assign SERIAL_RX = p3_sync_r[RXD_BIT];
	assign EXTERNAL_INTERRUPT_ZERO_PIN = p3_sync_r[EXT0_BIT];
	assign EXTERNAL_INTERRUPT_ONE_PIN = p3_sync_r[EXT1_BIT];
	assign TIMER_ZERO_COUNT_INPUT = p3_sync_r[TMR0_BIT];
	assign TIMER_ONE_COUNT_INPUT = p3_sync_r[TMR1_BIT];
	assign PROG_CTRL = PROG_MODE ? p3_sync_r[PCTL_BIT3:PCTL_BIT0] : 4'h0;

	// helper: clocks since the last machine cycle
	logic [4:0] gap_r;
	logic       seen_r;
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			gap_r <= 5'h0;
			seen_r <= 1'b0;
		end else if (mc_pulse) begin
			gap_r <= 5'h0;
			seen_r <= 1'b1;
		end else if (osc_run) begin
			gap_r <= gap_r + 5'h1;
		end
	end

	a_mc_period: assert property (@(posedge CLK_SYS) disable iff (RST)
		mc_pulse && seen_r |-> gap_r == 5'(OSC_PER_MC - 1))
		else $error("machine cycle period wrong");

	a_half_toggle: assert property (@(posedge CLK_SYS) disable iff (RST)
		osc_run |=> half_r != $past(half_r))
		else $error("divide-by-two stage stuck");

	a_pdown_static: assert property (@(posedge CLK_SYS) disable iff (RST)
		mode_r == IOP_PDOWN |=> mode_r == IOP_PDOWN && !mc_pulse && $stable(p1_sync_r))
		else $error("activity in power-down");

	a_idle_wake: assert property (@(posedge CLK_SYS) disable iff (RST)
		mode_r == IOP_IDLE && WAKE_IRQ |=> mode_r == IOP_RUN && !CPU_HALT)
		else $error("idle did not end on wake");

	a_reset_pins: assert property (@(posedge CLK_SYS)
		RST |-> P1_OE_N == ALL_ONE && P3_OE_N == ALL_ONE)
		else $error("pins not high in reset");

	a_full_reset: assert property (@(posedge CLK_SYS)
		$rose(DEVICE_RESET) |-> $past(RST) && $past(RST, RST_HOLD_CLK))
		else $error("device reset too early");

	a_reset_drop: assert property (@(posedge CLK_SYS)
		!RST |=> !DEVICE_RESET)
		else $error("device reset without input");

	a_latch_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
		P1_WR_EN && !PROG_MODE && !prog_oe_r |=> P1_OE_N == $past(P1_WR_DATA) || prog_oe_r)
		else $error("first port not following latch");

	a_bit6_nopin: assert property (@(posedge CLK_SYS) disable iff (RST)
		mc_pulse |=> P3_OE_N[CMP_OUT_BIT] && P3_RD_DATA[CMP_OUT_BIT] == $past(COMPARATOR_RESULT))
		else $error("bit 6 not comparator");

	a_txd_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
		!SERIAL_TX |-> !P3_OE_N[TXD_BIT])
		else $error("transmit low not driven");

	a_read_sync: assert property (@(posedge CLK_SYS) disable iff (RST)
		$changed(P1_RD_DATA) |-> $past(mc_pulse))
		else $error("read changed off machine cycle");

	a_prog_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
		PROG_MODE && PROG_DATA_OE |=> P1_OE_N == ALL_ZERO && P1_OUT == $past(PROG_DATA_WR))
		else $error("programming data not driven");

	a_idle_clock: assert property (@(posedge CLK_SYS) disable iff (RST)
		mode_r == IOP_IDLE |-> CPU_HALT && OSC_RUN)
		else $error("idle stopped the clock");

	a_run_active: assert property (@(posedge CLK_SYS) disable iff (RST)
		mode_r == IOP_RUN |-> !CPU_HALT && OSC_RUN)
		else $error("core halted while running");

	a_pdown_osc: assert property (@(posedge CLK_SYS) disable iff (RST)
		mode_r == IOP_PDOWN |-> !OSC_RUN && CPU_HALT)
		else $error("oscillator running in power-down");

	a_reset_held: assert property (@(posedge CLK_SYS)
		DEVICE_RESET |-> $past(RST))
		else $error("device reset after input low");

	a_ctrl_quiet: assert property (@(posedge CLK_SYS) disable iff (RST)
		!PROG_MODE |-> PROG_CTRL == '0)
		else $error("programming controls outside programming");

	a_p3_latch: assert property (@(posedge CLK_SYS) disable iff (RST)
		P3_WR_EN |=> P3_OE_N[TMR1_BIT:EXT0_BIT] == $past(P3_WR_DATA[TMR1_BIT:EXT0_BIT]))
		else $error("second port not following latch");

endmodule
`default_nettype wire

// File: tb/iop_board.sv
`timescale 1ns/1ns
`default_nettype none
module iop_board
	import iop_pkg::*;
(
	// device side
	input  wire logic            clk,
	input  wire logic [P1_W-1:0] p1_out,
	input  wire logic [P1_W-1:0] p1_oe_n,
	input  wire logic [P3_W-1:0] p3_out,
	input  wire logic [P3_W-1:0] p3_oe_n,
	// external drivers
	input  wire logic [P1_W-1:0] p1_ext_en,
	input  wire logic [P1_W-1:0] p1_ext_val,
	input  wire logic [P3_W-1:0] p3_ext_en,
	input  wire logic [P3_W-1:0] p3_ext_val,
	// resolved pin levels
	output logic      [P1_W-1:0] p1_in,
	output logic      [P3_W-1:0] p3_in
);
	logic tog_r = 1'b0;
	// no pin here, so the level keeps moving
	always_ff @(posedge clk) begin
		tog_r <= ~tog_r;
	end
	always_comb begin
		for (int i = 0; i < P1_W; i++) begin
			p1_in[i] = !p1_oe_n[i] ? p1_out[i] : p1_ext_en[i] ? p1_ext_val[i] : 1'b1;
		end
		for (int i = 0; i < P3_W; i++) begin
			p3_in[i] = !p3_oe_n[i] ? p3_out[i] : p3_ext_en[i] ? p3_ext_val[i] : 1'b1;
		end
		p3_in[CMP_OUT_BIT] = tog_r;
	end
endmodule
`default_nettype wire

// File: tb/tb_iop_ports.sv
`timescale 1ns/1ns
`default_nettype none
module tb_iop_ports;
	import iop_pkg::*;
	logic       CLK_SYS, RST, P1_WR_EN, P3_WR_EN, COMPARATOR_RESULT, SERIAL_TX, PROG_MODE, PROG_DATA_OE;
	logic       IDLE_REQ, PDOWN_REQ, WAKE_IRQ, CPU_HALT, OSC_RUN, MACHINE_CYCLE, DEVICE_RESET, SERIAL_RX;
	logic       CMP_P, CMP_N, EXT0, EXT1, TM0, TM1;
	logic [7:0] P1_WR_DATA, P3_WR_DATA, P1_RD_DATA, P3_RD_DATA, P1_IN, P1_OUT, P1_OE_N, P1_PULLUP_EN;
	logic [7:0] P3_IN, P3_OUT, P3_OE_N, P3_PULLUP_EN, PROG_DATA_WR, PROG_DATA_RD, e1_en, e1_val, e3_en, e3_val;
	logic [3:0] PROG_CTRL;
	int         mismatches = 0;
	int         checked = 0;
	int         n;

	iop_ports i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .P1_WR_EN(P1_WR_EN), .P1_WR_DATA(P1_WR_DATA),
		.P3_WR_EN(P3_WR_EN), .P3_WR_DATA(P3_WR_DATA), .P1_RD_DATA(P1_RD_DATA), .P3_RD_DATA(P3_RD_DATA),
		.P1_IN(P1_IN), .P1_OUT(P1_OUT), .P1_OE_N(P1_OE_N), .P1_PULLUP_EN(P1_PULLUP_EN), .P3_IN(P3_IN),
		.P3_OUT(P3_OUT), .P3_OE_N(P3_OE_N), .P3_PULLUP_EN(P3_PULLUP_EN), .COMPARATOR_RESULT(COMPARATOR_RESULT),
		.COMPARATOR_POSITIVE_INPUT(CMP_P), .COMPARATOR_NEGATIVE_INPUT(CMP_N), .SERIAL_TX(SERIAL_TX),
		.SERIAL_RX(SERIAL_RX), .EXTERNAL_INTERRUPT_ZERO_PIN(EXT0), .EXTERNAL_INTERRUPT_ONE_PIN(EXT1),
		.TIMER_ZERO_COUNT_INPUT(TM0), .TIMER_ONE_COUNT_INPUT(TM1), .PROG_MODE(PROG_MODE),
		.PROG_DATA_OE(PROG_DATA_OE), .PROG_DATA_WR(PROG_DATA_WR), .PROG_DATA_RD(PROG_DATA_RD),
		.PROG_CTRL(PROG_CTRL), .IDLE_REQ(IDLE_REQ), .PDOWN_REQ(PDOWN_REQ), .WAKE_IRQ(WAKE_IRQ),
		.CPU_HALT(CPU_HALT), .OSC_RUN(OSC_RUN), .MACHINE_CYCLE(MACHINE_CYCLE), .DEVICE_RESET(DEVICE_RESET));

	iop_board i_board (.clk(CLK_SYS), .p1_out(P1_OUT), .p1_oe_n(P1_OE_N), .p3_out(P3_OUT), .p3_oe_n(P3_OE_N),
		.p1_ext_en(e1_en), .p1_ext_val(e1_val), .p3_ext_en(e3_en), .p3_ext_val(e3_val),
		.p1_in(P1_IN), .p3_in(P3_IN));

	initial begin
		CLK_SYS = 1'b0;
		forever #4 CLK_SYS = ~CLK_SYS;
	end

	task end_of_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task tick(input int k);
		repeat (k) begin
			@(posedge CLK_SYS);
			#1;
		end
	endtask

	task chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// returns ticks taken to reach the next pulse
	task wait_mc(output int k);
		k = 1;
		tick(1);
		while (MACHINE_CYCLE !== 1'b1 && k < 40) begin
			tick(1);
			k++;
		end
		if (k >= 40) begin
			chk8(8'h0, 8'h1, "no machine cycle");
			end_of_test;
		end
	endtask

	// two stages of sampling need three pulses to be safe
	task sync3;
		repeat (3) wait_mc(n);
		tick(1);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] b);
		P1_WR_DATA = a;
		P3_WR_DATA = b;
		P1_WR_EN = 1'b1;
		P3_WR_EN = 1'b1;
		tick(1);
		P1_WR_EN = 1'b0;
		P3_WR_EN = 1'b0;
	endtask

	task t_write;
		wr(8'h5a, 8'hff);
		chk8(P1_OE_N, 8'h5a, "p1 latch");
		sync3;
		chk8(P1_RD_DATA, 8'h5a, "p1 pins");
		wait_mc(n);
		wait_mc(n);
		chk8(8'(n), 8'(OSC_PER_MC), "mc period");
		SERIAL_TX = 1'b0;
		tick(2);
		chk8(P3_OE_N, 8'hfd, "tx gate");
		SERIAL_TX = 1'b1;
	endtask

	task t_read;
		wr(8'hff, 8'hff);
		e1_en = 8'hff;
		e1_val = 8'ha6;
		e3_en = 8'hbf;
		e3_val = 8'h15;
		COMPARATOR_RESULT = 1'b1;
		sync3;
		chk8(P1_RD_DATA, 8'ha6, "p1 read");
		chk8(P3_RD_DATA, 8'h55, "p3 read");
		chk8({6'h0, CMP_N, CMP_P}, 8'h02, "cmp pins");
		chk8({3'h0, TM1, TM0, EXT1, EXT0, SERIAL_RX}, 8'h0b, "alt inputs");
		COMPARATOR_RESULT = 1'b0;
		sync3;
		chk8(P3_RD_DATA, 8'h15, "cmp bit");
	endtask

	task t_prog;
		PROG_MODE = 1'b1;
		PROG_DATA_OE = 1'b1;
		PROG_DATA_WR = 8'h3c;
		e3_val = 8'h28;
		tick(1);
		chk8(P1_OE_N, 8'h00, "prog oe");
		chk8(P1_OUT, 8'h3c, "prog out");
		sync3;
		chk8(PROG_DATA_RD, 8'h3c, "prog rd");
		chk8({4'h0, PROG_CTRL}, 8'h0a, "prog ctrl");
		PROG_MODE = 1'b0;
		PROG_DATA_OE = 1'b0;
		tick(2);
		chk8(P1_OE_N, 8'hff, "prog off");
		chk8({4'h0, PROG_CTRL}, 8'h00, "ctrl off");
	endtask

	task t_reset;
		wr(8'h00, 8'h00);
		chk8(P3_OE_N, 8'h40, "no pin six");
		chk8(P1_PULLUP_EN, 8'hfc, "p1 pulls");
		chk8(P3_PULLUP_EN, 8'hbf, "p3 pulls");
		chk8(P1_OUT, 8'h00, "p1 sinks");
		chk8(P3_OUT, 8'h00, "p3 sinks");
		SERIAL_TX = 1'b0;
		RST = 1'b1;
		#1;
		chk8(P1_OE_N & P3_OE_N, 8'hff, "async pins");
		tick(22);
		SERIAL_TX = 1'b1;
		chk8({7'h0, DEVICE_RESET}, 8'h00, "reset early");
		tick(2);
		chk8({7'h0, DEVICE_RESET}, 8'h01, "reset full");
		RST = 1'b0;
		tick(1);
	endtask

	task t_power;
		IDLE_REQ = 1'b1;
		tick(1);
		IDLE_REQ = 1'b0;
		chk8({7'h0, CPU_HALT}, 8'h01, "idle");
		wait_mc(n);
		wait_mc(n);
		chk8(8'(n), 8'(OSC_PER_MC), "idle pulses");
		WAKE_IRQ = 1'b1;
		tick(1);
		WAKE_IRQ = 1'b0;
		chk8({7'h0, CPU_HALT}, 8'h00, "wake");
		wr(8'hc3, 8'hff);
		PDOWN_REQ = 1'b1;
		tick(1);
		PDOWN_REQ = 1'b0;
		WAKE_IRQ = 1'b1;
		n = 0;
		repeat (30) begin
			tick(1);
			n += int'(MACHINE_CYCLE !== 1'b0);
		end
		chk8({6'h0, CPU_HALT, OSC_RUN}, 8'h02, "pdown");
		chk8(8'(n), 8'h00, "pdown pulses");
		chk8(P1_OE_N, 8'hc3, "kept");
		WAKE_IRQ = 1'b0;
		RST = 1'b1;
		tick(24);
		RST = 1'b0;
		tick(1);
		chk8({6'h0, CPU_HALT, OSC_RUN}, 8'h01, "pdown exit");
		chk8(P1_OE_N, 8'hff, "latch reinit");
	endtask

	initial begin
		{P1_WR_EN, P3_WR_EN, COMPARATOR_RESULT, PROG_MODE, PROG_DATA_OE, IDLE_REQ, PDOWN_REQ, WAKE_IRQ} = 8'h00;
		{P1_WR_DATA, P3_WR_DATA, PROG_DATA_WR, e1_en, e1_val, e3_en, e3_val} = '0;
		SERIAL_TX = 1'b1;
		RST = 1'b1;
		tick(8);
		RST = 1'b0;
		tick(1);
		t_write;
		t_read;
		t_prog;
		t_reset;
		t_power;
		end_of_test;
	end
endmodule
`default_nettype wire
